/* File: hdl/lmr_mode_regs.sv */
`timescale 1ns/1ps
`include "lmr_map.svh"
module lmr_mode_regs #(
   parameter logic [3:0] DENSITY = `LMR_DENS_1GB,
   parameter logic [1:0] IO_WIDTH = `LMR_WIDTH_X32,
   parameter logic [7:0] PAT_A = 8'h55,
   parameter logic [7:0] PAT_B = 8'h3C
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire lmr_pkg::lmr_cmd_type cmd,
   input wire logic zq_tied_to_supply,
   input wire logic [12:0] refresh_row,
   input wire logic [2:0] refresh_bank,
   output lmr_pkg::lmr_cfg_type cfg,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic cal_busy,
   output logic rzq_connected,
   output logic ca_training,
   output logic refresh_allow,
   output logic soft_reset
);
   lmr_pkg::lmr_cfg_type cfg_q, cfg_d;
   logic ca_q, ca_d;
   logic rst_q, rst_d;
   logic rzq_q, rzq_d;
   logic rdv_q, rdv_d;
   logic pat_q, pat_d;
   logic pat_sel_b;
   logic [7:0] reg_q, reg_d;
   logic allow_q, allow_d;
   logic busy_q;
   logic cal_start;
   logic init_pending_q, init_pending_d;
   lmr_pkg::lmr_cal_kind_type cal_kind;
   logic eng_busy, eng_done;
   logic [7:0] pat_rdata;
   logic wr;

   assign wr = cmd.wr;

   // Classify a calibration code; reserved codes map to none
   function automatic lmr_pkg::lmr_cal_kind_type cal_decode(input logic [7:0] code);
      unique case (code)
         `LMR_CAL_INIT: cal_decode = lmr_pkg::LMR_KIND_INIT;
         `LMR_CAL_LONG: cal_decode = lmr_pkg::LMR_KIND_LONG;
         `LMR_CAL_SHORT: cal_decode = lmr_pkg::LMR_KIND_SHORT;
         default: cal_decode = lmr_pkg::LMR_KIND_NONE;
      endcase
   endfunction

   // Geometry word built from the read-only fields
   function automatic logic [7:0] geom_word();
      logic [7:0] w;
      w = 8'h00;
      w[`LMR_TYPE_LSB +: 2] = `LMR_TYPE_CODE;
      w[`LMR_DENS_LSB +: 4] = DENSITY;
      w[`LMR_WIDTH_LSB +: 2] = IO_WIDTH;
      geom_word = w;
   endfunction

   // Calibration launch
   always_comb begin
      cal_kind = cal_decode(cmd.data);
      // defined codes only, ZQ not tied
      cal_start = wr && (cmd.addr == `LMR_ADDR_CAL) && !zq_tied_to_supply &&
                  (cal_kind != lmr_pkg::LMR_KIND_NONE);
   end

   lmr_cal_engine #(
      .CNT_W(8)
   ) u_cal (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .start(cal_start),
      .kind(cal_kind),
      .busy(eng_busy),
      .done(eng_done)
   );

   lmr_pattern_rom #(
      .PAT_A(PAT_A),
      .PAT_B(PAT_B)
   ) u_pat (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .sel_b(pat_sel_b),
      .rdata(pat_rdata)
   );

   // Writable state; unmapped or read-only addresses fall through unchanged
   always_comb begin
      cfg_d = cfg_q;
      ca_d = ca_q;
      rst_d = 1'b0;
      rzq_d = rzq_q;
      init_pending_d = init_pending_q;
      if (wr) begin
         unique case (cmd.addr)
            `LMR_ADDR_CAL: if (cmd.data == `LMR_CAL_ZQRST && !zq_tied_to_supply) begin
               rzq_d = 1'b0;
               init_pending_d = 1'b0;
            end
            `LMR_ADDR_TERM: begin
               cfg_d.dq_term = cmd.data[1:0];
               cfg_d.pd_term = cmd.data[`LMR_PDT_BIT];
            end
            `LMR_ADDR_BANK: cfg_d.bank_mask = cmd.data;
            `LMR_ADDR_SEG: cfg_d.seg_mask = cmd.data;
            `LMR_ADDR_CAT_IN1, `LMR_ADDR_CAT_IN2: ca_d = 1'b1;
            `LMR_ADDR_CAT_OUT: ca_d = 1'b0;
            `LMR_ADDR_RESET: begin
               rst_d = 1'b1;
               cfg_d.dq_term = `LMR_TERM_RST;
               cfg_d.pd_term = 1'b0;
               cfg_d.bank_mask = `LMR_MASK_RST;
               cfg_d.seg_mask = `LMR_MASK_RST;
               ca_d = 1'b0;
            end
            default: cfg_d = cfg_q;
         endcase
      end
      // record resistor presence when init calibration completes
      // After the write decode, so a finishing init beats a same-cycle ZQ reset
      if (eng_done && init_pending_q) begin
         rzq_d = 1'b1;
         init_pending_d = 1'b0;
      end
      // A new start comes last, so its pending mark survives an old completion
      if (cal_start) begin
         init_pending_d = (cal_kind == lmr_pkg::LMR_KIND_INIT);
      end
   end

   // Read path; pattern words arrive one cycle later through the pattern memory
   always_comb begin
      rdv_d = cmd.rd;
      pat_sel_b = (cmd.addr == `LMR_ADDR_PAT_B);
      // pattern reads take the memory path
      pat_d = cmd.rd && ((cmd.addr == `LMR_ADDR_PAT_A) || pat_sel_b);
      if (pat_q) begin
         // Extra cycle keeps the read data leaving straight from a register
         reg_d = pat_rdata;
      end else begin
         unique case (cmd.addr)
            `LMR_ADDR_GEOM: reg_d = geom_word();
            `LMR_ADDR_INFO: reg_d = 8'(rzq_q) << `LMR_INFO_RZQ_BIT;
            default: reg_d = 8'h00;
         endcase
      end
   end

   // segment from row bits 12:10, and bank mask together
   always_comb begin
      allow_d = !cfg_q.bank_mask[refresh_bank] &&
                !cfg_q.seg_mask[refresh_row[`LMR_ROW_SEG_LSB +: 3]];
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= '0;
         ca_q <= 1'b0;
         rst_q <= 1'b0;
         rzq_q <= 1'b0;
         init_pending_q <= 1'b0;
         rdv_q <= 1'b0;
         pat_q <= 1'b0;
         reg_q <= 8'h00;
         allow_q <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         ca_q <= ca_d;
         rst_q <= rst_d;
         rzq_q <= rzq_d;
         init_pending_q <= init_pending_d;
         rdv_q <= rdv_d;
         pat_q <= pat_d;
         reg_q <= reg_d;
         allow_q <= allow_d;
         busy_q <= eng_busy;
      end
   end

   assign cfg = cfg_q;
   assign rd_data = reg_q;
   assign rd_valid = rdv_q;
   assign cal_busy = busy_q;
   assign rzq_connected = rzq_q;
   assign ca_training = ca_q;
   assign refresh_allow = allow_q;
   assign soft_reset = rst_q;

   // termination follows write one cycle later
   property p_term_wr;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_TERM) |=> (cfg.dq_term == $past(cmd.data[1:0]));
   endproperty
   a_term_wr: assert property (p_term_wr) else $error("termination not updated");
   property p_pd_wr;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_TERM) |=> (cfg.pd_term == $past(cmd.data[2]));
   endproperty
   a_pd_wr: assert property (p_pd_wr) else $error("power-down select wrong");
   property p_bank;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_BANK) |=> (cfg.bank_mask == $past(cmd.data));
   endproperty
   a_bank: assert property (p_bank) else $error("bank mask wrong");
   property p_seg;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_SEG) |=> (cfg.seg_mask == $past(cmd.data));
   endproperty
   a_seg: assert property (p_seg) else $error("segment mask wrong");
   property p_rsv_cal;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_CAL && cal_decode(cmd.data) == lmr_pkg::LMR_KIND_NONE
          && !eng_busy) |=> ##1 !cal_busy;
   endproperty
   a_rsv_cal: assert property (p_rsv_cal) else $error("reserved code started work");
   property p_zq_tied;
      @(posedge sys_clk) disable iff (!nrst)
         (zq_tied_to_supply && wr && cmd.addr == `LMR_ADDR_CAL && !eng_busy) |=> ##1 !cal_busy;
   endproperty
   a_zq_tied: assert property (p_zq_tied) else $error("ZQ command taken while tied");
   property p_cal_go;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_CAL && cmd.data == `LMR_CAL_LONG && !zq_tied_to_supply)
         |=> ##1 cal_busy;
   endproperty
   a_cal_go: assert property (p_cal_go) else $error("long calibration did not start");
   sequence s_enter;
      wr && (cmd.addr == `LMR_ADDR_CAT_IN1 || cmd.addr == `LMR_ADDR_CAT_IN2);
   endsequence
   property p_ca_in;
      @(posedge sys_clk) disable iff (!nrst) s_enter |=> ca_training;
   endproperty
   a_ca_in: assert property (p_ca_in) else $error("training not entered");
   property p_ca_out;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_CAT_OUT) |=> !ca_training;
   endproperty
   a_ca_out: assert property (p_ca_out) else $error("training not left");
   property p_geom;
      @(posedge sys_clk) disable iff (!nrst)
         (cmd.rd && cmd.addr == `LMR_ADDR_GEOM) |=> (rd_valid && rd_data[1:0] == 2'h3);
   endproperty
   a_geom: assert property (p_geom) else $error("type code wrong");
   property p_pat_b;
      @(posedge sys_clk) disable iff (!nrst)
         (cmd.rd && cmd.addr == `LMR_ADDR_PAT_B) |=> ##1 (rd_data == PAT_B);
   endproperty
   a_pat_b: assert property (p_pat_b) else $error("pattern B wrong");
   property p_reset;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_RESET) |=> (soft_reset && cfg.bank_mask == 8'h00);
   endproperty
   a_reset: assert property (p_reset) else $error("soft reset missing");
   property p_pat_a;
      @(posedge sys_clk) disable iff (!nrst)
         (cmd.rd && cmd.addr == `LMR_ADDR_PAT_A) |=> ##1 (rd_data == PAT_A);
   endproperty
   a_pat_a: assert property (p_pat_a) else $error("pattern A wrong");
   property p_dens;
      @(posedge sys_clk) disable iff (!nrst)
         (cmd.rd && cmd.addr == `LMR_ADDR_GEOM) |=> (rd_data[`LMR_DENS_LSB +: 4] == DENSITY);
   endproperty
   a_dens: assert property (p_dens) else $error("density code wrong");
   property p_width;
      @(posedge sys_clk) disable iff (!nrst)
         (cmd.rd && cmd.addr == `LMR_ADDR_GEOM) |=> (rd_data[`LMR_WIDTH_LSB +: 2] == IO_WIDTH);
   endproperty
   a_width: assert property (p_width) else $error("width code wrong");
   property p_zq_rst;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_CAL && cmd.data == `LMR_CAL_ZQRST &&
          !zq_tied_to_supply && !(eng_done && init_pending_q)) |=> !rzq_connected;
   endproperty
   a_zq_rst: assert property (p_zq_rst) else $error("ZQ reset kept resistor flag");
   sequence s_init_end;
      eng_done && init_pending_q;
   endsequence
   property p_rzq_set;
      @(posedge sys_clk) disable iff (!nrst) s_init_end |=> rzq_connected;
   endproperty
   a_rzq_set: assert property (p_rzq_set) else $error("resistor flag not set");
   property p_bank_blk;
      @(posedge sys_clk) disable iff (!nrst)
         cfg.bank_mask[refresh_bank] |=> !refresh_allow;
   endproperty
   a_bank_blk: assert property (p_bank_blk) else $error("masked bank refreshed");
   property p_seg_blk;
      @(posedge sys_clk) disable iff (!nrst)
         cfg.seg_mask[refresh_row[`LMR_ROW_SEG_LSB +: 3]] |=> !refresh_allow;
   endproperty
   a_seg_blk: assert property (p_seg_blk) else $error("masked segment refreshed");
   property p_ro_wr;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && (cmd.addr == `LMR_ADDR_GEOM || cmd.addr == `LMR_ADDR_INFO))
         |=> ($stable(cfg) && $stable(ca_training));
   endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("read-only write changed state");
   property p_rst_clear;
      @(posedge sys_clk) disable iff (!nrst)
         (wr && cmd.addr == `LMR_ADDR_RESET) |=> (!ca_training && cfg.seg_mask == 8'h00);
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("soft reset kept state");
endmodule // lmr_mode_regs

/* File: hdl/lmr_map.svh */
// What this block does
// - Register 08H bits 1:0 read as 11, marking a low-power DDR3 part.
// - Register 08H bits 5:2 report density; 0100 means one gigabit.
// - Register 08H bits 7:6 report width; 00 is x32, 01 is x16.
// - Writing FF, AB or 56 to 0AH starts init, long or short calibration.
// - Writing C3 to 0AH restores default calibration (ZQ reset).
// - Reserved calibration codes are ignored and start nothing.
// - With ZQ tied to the supply, every calibration code is ignored.
// - The init calibration records resistor presence in register 00H.
// - Register 0BH bits 1:0 select DQ termination; reset value disables it.
// - Register 0BH bit 2 keeps termination on in power-down when set.
// - Register 10H bit n blocks refresh of bank n when set.
// - Register 11H bit n blocks refresh of segment n when set.
// - Segment n is the rows whose address bits 12:10 equal n.
// - A read of 20H returns DQ calibration pattern A.
// - A read of 28H returns DQ calibration pattern B.
// - A write to 29H enters command-address training.
// - A write to 30H also enters command-address training.
// - A write to 2AH leaves command-address training.
// - A write to 3FH resets the device; data is don't-care or FC.
`ifndef LMR_MAP_SVH
`define LMR_MAP_SVH
`define LMR_ADDR_INFO 8'h00
`define LMR_ADDR_GEOM 8'h08
`define LMR_ADDR_CAL 8'h0A
`define LMR_ADDR_TERM 8'h0B
`define LMR_ADDR_BANK 8'h10
`define LMR_ADDR_SEG 8'h11
`define LMR_ADDR_PAT_A 8'h20
`define LMR_ADDR_PAT_B 8'h28
`define LMR_ADDR_CAT_IN1 8'h29
`define LMR_ADDR_CAT_OUT 8'h2A
`define LMR_ADDR_CAT_IN2 8'h30
`define LMR_ADDR_RESET 8'h3F
`define LMR_TYPE_LSB 0
`define LMR_TYPE_CODE 2'h3
`define LMR_DENS_LSB 2
`define LMR_DENS_1GB 4'h4
`define LMR_WIDTH_LSB 6
`define LMR_WIDTH_X32 2'h0
`define LMR_WIDTH_X16 2'h1
`define LMR_CAL_INIT 8'hFF
`define LMR_CAL_LONG 8'hAB
`define LMR_CAL_SHORT 8'h56
`define LMR_CAL_ZQRST 8'hC3
`define LMR_TERM_RST 2'h0
`define LMR_PDT_BIT 2
`define LMR_MASK_RST 8'h00
`define LMR_INFO_RZQ_BIT 4
`define LMR_ROW_SEG_LSB 10
`define LMR_CAL_INIT_NS 1000
`define LMR_CAL_LONG_NS 360
`define LMR_CAL_SHORT_NS 90
`define LMR_CLK_NS 5
`endif

/* File: hdl/lmr_pkg.sv */
package lmr_pkg;
   // Mode register command from the controller
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } lmr_cmd_type;
   // Settings that steer the rest of the device
   typedef struct packed {
      logic [1:0] dq_term;
      logic pd_term;
      logic [7:0] bank_mask;
      logic [7:0] seg_mask;
   } lmr_cfg_type;
   typedef enum logic [1:0] {
      LMR_CAL_IDLE = 2'h0,
      LMR_CAL_RUN = 2'h1,
      LMR_CAL_DONE = 2'h3
   } lmr_cal_state_type;
   typedef enum logic [1:0] {
      LMR_KIND_NONE = 2'h0,
      LMR_KIND_INIT = 2'h1,
      LMR_KIND_LONG = 2'h2,
      LMR_KIND_SHORT = 2'h3
   } lmr_cal_kind_type;
endpackage

/* File: hdl/lmr_cal_engine.sv */
`timescale 1ns/1ps
`include "lmr_map.svh"
module lmr_cal_engine #(
   parameter int CNT_W = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic start,
   input wire lmr_pkg::lmr_cal_kind_type kind,
   output logic busy,
   output logic done
);
   localparam logic [CNT_W-1:0] INIT_CYC = CNT_W'(`LMR_CAL_INIT_NS / `LMR_CLK_NS);
   localparam logic [CNT_W-1:0] LONG_CYC = CNT_W'(`LMR_CAL_LONG_NS / `LMR_CLK_NS);
   localparam logic [CNT_W-1:0] SHORT_CYC = CNT_W'(`LMR_CAL_SHORT_NS / `LMR_CLK_NS);
   lmr_pkg::lmr_cal_state_type state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;

   // Length of each calibration kind
   function automatic logic [CNT_W-1:0] cal_len(input lmr_pkg::lmr_cal_kind_type k);
      unique case (k)
         lmr_pkg::LMR_KIND_INIT: cal_len = INIT_CYC;
         lmr_pkg::LMR_KIND_LONG: cal_len = LONG_CYC;
         default: cal_len = SHORT_CYC;
      endcase
   endfunction

   // Count down the calibration latency; a new start restarts it
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (start) begin
         state_d = lmr_pkg::LMR_CAL_RUN;
         cnt_d = cal_len(kind);
      end else begin
         unique case (state_q)
            lmr_pkg::LMR_CAL_IDLE: state_d = lmr_pkg::LMR_CAL_IDLE;
            lmr_pkg::LMR_CAL_RUN: begin
               cnt_d = cnt_q - CNT_W'(1);
               if (cnt_q == CNT_W'(1)) begin
                  state_d = lmr_pkg::LMR_CAL_DONE;
               end
            end
            lmr_pkg::LMR_CAL_DONE: state_d = lmr_pkg::LMR_CAL_IDLE;
            default: state_d = lmr_pkg::LMR_CAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= lmr_pkg::LMR_CAL_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   assign busy = (state_q == lmr_pkg::LMR_CAL_RUN);
   assign done = (state_q == lmr_pkg::LMR_CAL_DONE);
endmodule // lmr_cal_engine

/* File: hdl/lmr_pattern_rom.sv */
`timescale 1ns/1ps
module lmr_pattern_rom #(
   parameter logic [7:0] PAT_A = 8'h55,
   parameter logic [7:0] PAT_B = 8'h3C
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic sel_b,
   output logic [7:0] rdata
);
   logic [7:0] rdata_q, rdata_d;

   // Pattern choice; read data leave from a register
   always_comb begin
      rdata_d = sel_b ? PAT_B : PAT_A;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;
endmodule // lmr_pattern_rom

/* File: bench/lmr_host_model.sv */
`timescale 1ns/1ps
// Controller side, one mode-register command per call
module lmr_host_model (
   input wire logic sys_clk,
   output lmr_pkg::lmr_cmd_type cmd
);
   // Idle command lines at time zero
   initial begin
      cmd = '0;
   end

   // no check on code or address
   // Only the caller chooses a reserved code or address, and then on purpose
   task automatic mr_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      cmd.wr = 1'h1;
      cmd.addr = addr;
      cmd.data = data;
      @(negedge sys_clk);
      cmd.wr = 1'h0;
      cmd.data = ~data; // Stale data lines never repeat the last byte
   endtask

   // Address held after the strobe, since pattern data lags one more cycle
   task automatic mr_read(input logic [7:0] addr);
      @(negedge sys_clk);
      cmd.rd = 1'h1;
      cmd.addr = addr;
      cmd.data = ~cmd.data;
      @(negedge sys_clk);
      cmd.rd = 1'h0;
   endtask
endmodule // lmr_host_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] PAT_A = 8'h96;
   localparam logic [7:0] PAT_B = 8'h69;
   localparam logic [7:0] RSV_ADDR [9] = '{8'h00, 8'h09, 8'h0C, 8'h12, 8'h21, 8'h2B, 8'h31,
                                           8'h40, 8'hFF};
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   logic zq_tied_to_supply = 1'h0;
   logic [12:0] refresh_row = 13'h0000;
   logic [2:0] refresh_bank = 3'h0;
   lmr_pkg::lmr_cmd_type cmd;
   lmr_pkg::lmr_cfg_type cfg;
   logic [7:0] rd_data;
   logic rd_valid, cal_busy, rzq_connected, ca_training, refresh_allow, soft_reset;
   logic [7:0] d1, d2;
   logic v;
   int num_errors = 0;
   int checks = 0;

   // Free-running 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   lmr_host_model host (.sys_clk(sys_clk), .cmd(cmd));

   lmr_mode_regs #(.PAT_A(PAT_A), .PAT_B(PAT_B)) uut (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .cmd(cmd),
      .zq_tied_to_supply(zq_tied_to_supply),
      .refresh_row(refresh_row),
      .refresh_bank(refresh_bank),
      .cfg(cfg),
      .rd_data(rd_data),
      .rd_valid(rd_valid),
      .cal_busy(cal_busy),
      .rzq_connected(rzq_connected),
      .ca_training(ca_training),
      .refresh_allow(refresh_allow),
      .soft_reset(soft_reset)
   );

   // Wide enough for the whole config struct
   task automatic chk(input string name, input logic [18:0] exp, input logic [18:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // First sample is one cycle after the strobe, second one cycle later
   task automatic rd(input logic [7:0] a);
      host.mr_read(a);
      v = rd_valid;
      d1 = rd_data;
      @(negedge sys_clk);
      d2 = rd_data;
   endtask

   // Counts busy cycles over a window longer than the slowest calibration
   task automatic cal(input logic [7:0] code, input int exp_len);
      int n;
      n = 0;
      host.mr_write(8'h0A, code);
      repeat (260) begin
         @(negedge sys_clk);
         if (cal_busy === 1'h1) n++;
      end
      chk("cal busy cycles", 19'(exp_len), 19'(n));
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      nrst = 1'h1;
      chk("cfg reset", 19'h00000, cfg);
      chk("allow reset", 19'h1, 19'(refresh_allow));
      rd(8'h08);
      chk("geom valid", 19'h1, 19'(v));
      chk("geom", 19'({2'h0, 4'h4, 2'h3}), 19'(d1));
      host.mr_write(8'h08, 8'hFF);
      rd(8'h08);
      chk("geom after write", 19'h13, 19'(d1));
      rd(8'h20);
      chk("pattern a", 19'(PAT_A), 19'(d2));
      rd(8'h28);
      chk("pattern b", 19'(PAT_B), 19'(d2));
      rd(8'h09);
      chk("reserved read", 19'h0, 19'(d1));
      rd(8'h00);
      chk("info at reset", 19'h0, 19'(d1));
      $display("test identification done");
      for (int i = 0; i < 8; i++) begin
         host.mr_write(8'h0B, 8'(i));
         chk("term", {2'(i), 1'(i >> 2), 16'h0000}, cfg);
      end
      foreach (RSV_ADDR[k]) begin
         host.mr_write(RSV_ADDR[k], 8'hFF);
         chk("cfg kept", {2'h3, 1'h1, 16'h0000}, cfg);
         chk("training kept", 19'h0, 19'(ca_training));
      end
      $display("test termination done");
      host.mr_write(8'h10, 8'h05);
      host.mr_write(8'h11, 8'h80);
      for (int b = 0; b < 8; b++) begin
         for (int s = 0; s < 8; s++) begin
            refresh_bank = 3'(b);
            refresh_row = {3'(s), 10'h2AA};
            @(negedge sys_clk);
            chk("allow", 19'(b != 0 && b != 2 && s != 7), 19'(refresh_allow));
         end
      end
      $display("test refresh masks done");
      cal(8'hFF, 200);
      chk("rzq", 19'h1, 19'(rzq_connected));
      rd(8'h00);
      chk("info rzq", 19'h10, 19'(d1));
      cal(8'hAB, 72);
      cal(8'h56, 18);
      cal(8'h12, 0);
      cal(8'hC3, 0);
      chk("rzq cleared", 19'h0, 19'(rzq_connected));
      rd(8'h00);
      chk("info cleared", 19'h0, 19'(d1));
      zq_tied_to_supply = 1'h1;
      cal(8'hFF, 0);
      cal(8'hAB, 0);
      chk("rzq tied", 19'h0, 19'(rzq_connected));
      $display("test calibration done");
      host.mr_write(8'h29, 8'h00);
      chk("train in one", 19'h1, 19'(ca_training));
      host.mr_write(8'h2A, 8'h00);
      chk("train out", 19'h0, 19'(ca_training));
      host.mr_write(8'h30, 8'h00);
      chk("train in two", 19'h1, 19'(ca_training));
      host.mr_write(8'h3F, 8'hFC);
      chk("soft reset", 19'h1, 19'(soft_reset));
      @(negedge sys_clk);
      chk("soft reset end", 19'h0, 19'(soft_reset));
      chk("cfg cleared", 19'h00000, cfg);
      chk("train cleared", 19'h0, 19'(ca_training));
      host.mr_write(8'h3F, 8'h5A);
      chk("soft reset any data", 19'h1, 19'(soft_reset));
      $display("test training and reset done");
      end_of_test();
   end

   // Hang guard, well past the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      end_of_test();
   end
endmodule // tb_top
